// ==== hw/sgc_pkg.sv ====
package sgc_pkg;
    // ***********************************************
    // Addresses and layout
    // ***********************************************
    localparam logic [6:0] SGC_ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] SGC_ADDR_HW_CONFIG   = 7'h02;
    localparam logic [6:0] SGC_ADDR_WATCHDOG    = 7'h03;
    localparam logic [7:0] SGC_RST_MODE_SUPPLY  = 8'h00;
    localparam logic [7:0] SGC_RST_HW_CONFIG    = 8'h00;
    localparam logic [7:0] SGC_RST_WATCHDOG     = 8'h14;
    localparam logic [7:0] SGC_HW_SOFT_KEEP     = 8'h88;
    localparam logic [7:0] SGC_HW_WMASK         = 8'hFB;
    localparam logic [7:0] SGC_WD_WMASK         = 8'hF7;
    localparam logic [7:0] SGC_WD_RESTART_KEEP  = 8'hB0;
    localparam logic [7:0] SGC_WD_RESTART_VAL   = 8'h04;
    localparam logic [4:0] SGC_FRAME_BITS       = 5'h10;
    localparam int         SGC_MODE_HI          = 7;
    localparam int         SGC_MODE_LO          = 6;
    localparam int         SGC_VCC3_EN_BIT      = 5;
    localparam int         SGC_V2_HI            = 4;
    localparam int         SGC_V2_LO            = 3;
    localparam int         SGC_OV_RESP_BIT      = 2;
    localparam int         SGC_VSEL_BIT         = 7;
    localparam int         SGC_SRRO_BIT         = 6;
    localparam int         SGC_FO_BIT           = 5;
    localparam int         SGC_UVSD_BIT         = 4;
    localparam int         SGC_LS_BIT           = 3;
    localparam int         SGC_LSSTP_BIT        = 1;
    localparam int         SGC_CFG_BIT          = 0;
    localparam int         SGC_WDSTP_BIT        = 6;
    localparam int         SGC_WDWIN_BIT        = 5;
    localparam int         SGC_WDBUS_BIT        = 4;

    typedef enum logic [1:0] {
        SGC_MODE_NORMAL = 2'b00,
        SGC_MODE_SLEEP  = 2'b01,
        SGC_MODE_STOP   = 2'b10,
        SGC_MODE_SOFT   = 2'b11
    } sgc_mode_e;

    localparam logic [1:0] SGC_V2_OFF = 2'b00;

    // Watchdog period lookup in milliseconds.
    function automatic logic [9:0] sgc_wd_period_ms(input logic [2:0] code);
        case (code)
            3'b000:  return 10'h00A;
            3'b001:  return 10'h014;
            3'b010:  return 10'h032;
            3'b011:  return 10'h064;
            3'b100:  return 10'h0C8;
            3'b101:  return 10'h1F4;
            default: return 10'h000;
        endcase
    endfunction : sgc_wd_period_ms
endpackage : sgc_pkg

// ==== hw/sgc_frame_if.sv ====
`timescale 1ns/1ns
// ***********************************************
// Frame carrier between shifter and register bank
// ***********************************************
interface sgc_frame_if;
    logic       done;
    logic       write;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport shifter (output done, output write, output addr, output wdata, input rdata);
    modport bank    (input done, input write, input addr, input wdata, output rdata);
endinterface : sgc_frame_if

// ==== hw/sgc_spi_shift.sv ====
`timescale 1ns/1ns
module sgc_spi_shift
    import sgc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Serial pins, sampled synchronously
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    // Frame to the register bank
    sgc_frame_if.shifter     frm
);
    logic [15:0] sh_r, sh_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic        sck_r, sck_nxt;
    logic        cs_r, cs_nxt;
    logic [7:0]  out_r, out_nxt;
    logic        miso_r, miso_nxt;
    logic        done_r, done_nxt;

    // Data shifts MSB first: address, access bit, then data byte.
    always_comb begin
        sh_nxt   = sh_r;
        cnt_nxt  = cnt_r;
        out_nxt  = out_r;
        miso_nxt = miso_r;
        done_nxt = 1'b0;
        sck_nxt  = spi_sck;
        cs_nxt   = spi_cs_n;
        if (spi_cs_n) begin
            cnt_nxt = 5'h00;
            // Commit only on release of a full frame.
            if (!cs_r && cnt_r == SGC_FRAME_BITS) begin
                done_nxt = 1'b1;
            end
        end else begin
            if (cs_r) begin
                out_nxt = frm.rdata;
            end
            if (spi_sck && !sck_r && cnt_r != SGC_FRAME_BITS) begin
                sh_nxt  = {sh_r[14:0], spi_mosi};
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == 5'h07) begin
                    // Old contents go out, even on a write.
                    out_nxt = frm.rdata;
                end
            end
            if (!spi_sck && sck_r) begin
                miso_nxt = out_r[7];
                out_nxt  = {out_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sh_r   <= 16'h0000;
            cnt_r  <= 5'h00;
            sck_r  <= 1'b0;
            cs_r   <= 1'b1;
            out_r  <= 8'h00;
            miso_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            sh_r   <= sh_nxt;
            cnt_r  <= cnt_nxt;
            sck_r  <= sck_nxt;
            cs_r   <= cs_nxt;
            out_r  <= out_nxt;
            miso_r <= miso_nxt;
            done_r <= done_nxt;
        end
    end

    assign spi_miso  = miso_r;
    assign frm.done  = done_r;
    // The read-back lookup runs before the frame is complete, so it uses the low bits.
    assign frm.addr  = (cnt_r == 5'h07) ? sh_r[6:0] : sh_r[15:9];
    assign frm.write = sh_r[8];
    assign frm.wdata = sh_r[7:0];
endmodule : sgc_spi_shift

// ==== hw/sgc_ctrl_regs.sv ====
`timescale 1ns/1ns
module sgc_ctrl_regs
    import sgc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Serial pins
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    // Chip state machine events
    input  wire logic        restart_entry,
    input  wire logic        over_temp,
    input  wire logic        main_overvoltage,
    input  wire logic        battery_undervoltage,
    input  wire logic        failure_detected,
    input  wire logic        failure_status_clear,
    input  wire logic        fail_safe_active,
    input  wire logic        soft_fail_safe_cfg,
    input  wire logic        bus_wake_in_stop,
    // Mode and supply controls
    output logic [1:0]       operating_mode,
    output logic             soft_reset_pulse,
    output logic             reset_output_n,
    output logic             secondary_regulator_on,
    output logic             third_regulator_on,
    output logic [1:0]       reset_threshold_select,
    output logic             main_supply_overvoltage_flag,
    output logic             ov_restart_request,
    output logic             ov_fail_safe_request,
    // Hardware configuration controls
    output logic             third_regulator_voltage_select,
    output logic             load_sharing_active,
    output logic             failure_outputs,
    output logic             fail_after_first_wd_fault,
    // Watchdog controls
    output logic             watchdog_stop_disable,
    output logic             watchdog_window_mode,
    output logic             watchdog_bus_start,
    output logic [9:0]       watchdog_period_ms,
    output logic             watchdog_parity_ok
);
    sgc_frame_if frm ();

    sgc_spi_shift u_shift (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .spi_cs_n (spi_cs_n),
        .spi_sck  (spi_sck),
        .spi_mosi (spi_mosi),
        .spi_miso (spi_miso),
        .frm      (frm.shifter)
    );

    // ***********************************************
    // Register state
    // ***********************************************
    logic [7:0] ms_r, ms_nxt;
    logic [7:0] hw_r, hw_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic       fail_r, fail_nxt;
    logic       ov_r, ov_nxt;
    logic       soft_r, soft_nxt;
    logic       rst_n_r, rst_n_nxt;
    logic       wdbus_r, wdbus_nxt;
    logic       wr;

    assign wr = frm.done && frm.write;

    always_comb begin
        case (frm.addr)
            SGC_ADDR_MODE_SUPPLY: frm.rdata = ms_r;
            SGC_ADDR_HW_CONFIG:   frm.rdata = hw_r;
            SGC_ADDR_WATCHDOG:    frm.rdata = wd_r;
            default:              frm.rdata = 8'h00;
        endcase
    end

    always_comb begin
        ms_nxt    = ms_r;
        hw_nxt    = hw_r;
        wd_nxt    = wd_r;
        fail_nxt  = fail_r;
        ov_nxt    = ov_r;
        soft_nxt  = 1'b0;
        rst_n_nxt = 1'b1;
        wdbus_nxt = 1'b0;
        if (wr && frm.addr == SGC_ADDR_MODE_SUPPLY) begin
            if (frm.wdata[SGC_MODE_HI:SGC_MODE_LO] == SGC_MODE_SOFT) begin
                // Soft reset restores defaults but keeps two regulator bits.
                soft_nxt  = 1'b1;
                ms_nxt    = SGC_RST_MODE_SUPPLY;
                wd_nxt    = SGC_RST_WATCHDOG;
                hw_nxt    = hw_r & SGC_HW_SOFT_KEEP;
                rst_n_nxt = hw_r[SGC_SRRO_BIT];
            end else if (ms_r[SGC_MODE_HI:SGC_MODE_LO] == SGC_MODE_STOP
                         && frm.wdata[SGC_MODE_HI:SGC_MODE_LO] == SGC_MODE_SLEEP) begin
                // Whole register byte dropped rather than half-applied.
                ms_nxt = ms_r;
            end else begin
                ms_nxt = frm.wdata;
            end
        end
        if (wr && frm.addr == SGC_ADDR_HW_CONFIG) begin
            hw_nxt = frm.wdata & SGC_HW_WMASK;
        end
        if (wr && frm.addr == SGC_ADDR_WATCHDOG) begin
            wd_nxt = frm.wdata & SGC_WD_WMASK;
        end
        if (over_temp) begin
            ms_nxt[SGC_V2_HI:SGC_V2_LO] = SGC_V2_OFF;
        end
        if (restart_entry) begin
            ms_nxt[SGC_MODE_HI:SGC_MODE_LO] = SGC_MODE_NORMAL;
            ms_nxt[SGC_V2_HI:SGC_V2_LO]     = SGC_V2_OFF;
            hw_nxt[SGC_FO_BIT]              = 1'b0;
            wd_nxt = (wd_r & SGC_WD_RESTART_KEEP) | SGC_WD_RESTART_VAL;
        end
        // Failure latch: set wins over clear, restart drops it.
        if (restart_entry) begin
            fail_nxt = 1'b0;
        end else if (failure_detected) begin
            fail_nxt = 1'b1;
        end else if (failure_status_clear) begin
            fail_nxt = 1'b0;
        end
        if (main_overvoltage) begin
            ov_nxt = 1'b1;
        end else if (wr && frm.addr == SGC_ADDR_MODE_SUPPLY) begin
            ov_nxt = 1'b0;
        end
        wdbus_nxt = bus_wake_in_stop && wd_r[SGC_WDBUS_BIT];
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ms_r    <= SGC_RST_MODE_SUPPLY;
            hw_r    <= SGC_RST_HW_CONFIG;
            wd_r    <= SGC_RST_WATCHDOG;
            fail_r  <= 1'b0;
            ov_r    <= 1'b0;
            soft_r  <= 1'b0;
            rst_n_r <= 1'b1;
            wdbus_r <= 1'b0;
        end else begin
            ms_r    <= ms_nxt;
            hw_r    <= hw_nxt;
            wd_r    <= wd_nxt;
            fail_r  <= fail_nxt;
            ov_r    <= ov_nxt;
            soft_r  <= soft_nxt;
            rst_n_r <= rst_n_nxt;
            wdbus_r <= wdbus_nxt;
        end
    end

    // ***********************************************
    // Decoded outputs
    // ***********************************************
    logic [1:0] mode_r;
    logic       v2_r, v3_r, ovrs_r, ovfs_r, fo_r, ls_r, wdstp_r, ok_r;
    logic [9:0] per_r;
    logic       v2_nxt, v3_nxt, ls_nxt;

    always_comb begin
        unique case (ms_r[SGC_V2_HI:SGC_V2_LO])
            2'b00: v2_nxt = 1'b0;
            2'b01: v2_nxt = ms_r[SGC_MODE_HI:SGC_MODE_LO] == SGC_MODE_NORMAL;
            2'b10: v2_nxt = ms_r[SGC_MODE_HI:SGC_MODE_LO] == SGC_MODE_NORMAL
                         || ms_r[SGC_MODE_HI:SGC_MODE_LO] == SGC_MODE_STOP;
            2'b11: v2_nxt = !fail_safe_active;
        endcase
        // Undervoltage cut only when shutdown bit is clear.
        v3_nxt = ms_r[SGC_VCC3_EN_BIT]
              && !(battery_undervoltage && !hw_r[SGC_UVSD_BIT]);
        // Stop mode needs its own enable for sharing.
        ls_nxt = hw_r[SGC_LS_BIT] && (ms_r[SGC_MODE_HI:SGC_MODE_LO] != SGC_MODE_STOP
                                      || hw_r[SGC_LSSTP_BIT]);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_r  <= 2'b00;
            v2_r    <= 1'b0;
            v3_r    <= 1'b0;
            ovrs_r  <= 1'b0;
            ovfs_r  <= 1'b0;
            fo_r    <= 1'b0;
            ls_r    <= 1'b0;
            wdstp_r <= 1'b0;
            per_r   <= 10'h000;
            ok_r    <= 1'b0;
        end else begin
            mode_r  <= ms_r[SGC_MODE_HI:SGC_MODE_LO];
            v2_r    <= v2_nxt;
            v3_r    <= v3_nxt;
            // Only the enable turns an overvoltage into a state change.
            ovrs_r  <= main_overvoltage && ms_r[SGC_OV_RESP_BIT] && !soft_fail_safe_cfg;
            ovfs_r  <= main_overvoltage && ms_r[SGC_OV_RESP_BIT] && soft_fail_safe_cfg;
            fo_r    <= hw_r[SGC_FO_BIT] || fail_r;
            ls_r    <= ls_nxt;
            wdstp_r <= wd_r[SGC_WDSTP_BIT];
            per_r   <= sgc_wd_period_ms(wd_r[2:0]);
            ok_r    <= !(^wd_r);
        end
    end

    assign operating_mode                 = mode_r;
    assign soft_reset_pulse               = soft_r;
    assign reset_output_n                 = rst_n_r;
    assign secondary_regulator_on         = v2_r;
    assign third_regulator_on             = v3_r;
    assign reset_threshold_select         = ms_r[1:0];
    assign main_supply_overvoltage_flag   = ov_r;
    assign ov_restart_request             = ovrs_r;
    assign ov_fail_safe_request           = ovfs_r;
    assign third_regulator_voltage_select = hw_r[SGC_VSEL_BIT];
    assign load_sharing_active            = ls_r;
    assign failure_outputs                = fo_r;
    assign fail_after_first_wd_fault      = hw_r[SGC_CFG_BIT];
    assign watchdog_stop_disable          = wdstp_r;
    assign watchdog_window_mode           = wd_r[SGC_WDWIN_BIT];
    assign watchdog_bus_start             = wdbus_r;
    assign watchdog_period_ms             = per_r;
    assign watchdog_parity_ok             = ok_r;
endmodule : sgc_ctrl_regs

// ==== verif/sgc_ctrl_regs_sva.sv ====
`timescale 1ns/1ns
// ****
// Port checker
// ****
module sgc_ctrl_regs_sva (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Events
    input wire logic       restart_entry,
    input wire logic       over_temp,
    input wire logic       main_overvoltage,
    input wire logic       soft_fail_safe_cfg,
    input wire logic       failure_detected,
    // Controls
    input wire logic [1:0] operating_mode,
    input wire logic       soft_reset_pulse,
    input wire logic       reset_output_n,
    input wire logic       secondary_regulator_on,
    input wire logic       main_supply_overvoltage_flag,
    input wire logic       ov_restart_request,
    input wire logic       failure_outputs
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_ov_flag_set: assert property (
        main_overvoltage |-> ##[1:2] main_supply_overvoltage_flag)
        else $error("Overvoltage flag not raised.");
    a_ov_restart_cause: assert property (
        ov_restart_request |-> main_supply_overvoltage_flag && !$past(soft_fail_safe_cfg))
        else $error("Restart request without its cause.");
    a_restart_mode_normal: assert property (
        restart_entry |-> ##[1:3] operating_mode == 2'b00)
        else $error("Restart left the mode field set.");
    a_temp_regulator_off: assert property (
        over_temp |-> ##[1:3] !secondary_regulator_on)
        else $error("Secondary regulator on after overtemperature.");
    a_restart_fo_off: assert property (
        restart_entry && !failure_detected |-> ##[1:3] !failure_outputs)
        else $error("Failure outputs on after restart.");
    a_ro_single_low: assert property (
        $fell(reset_output_n) |=> reset_output_n)
        else $error("Reset output low longer than one cycle.");
    a_soft_mode_clear: assert property (
        soft_reset_pulse |-> ##[0:2] operating_mode == 2'b00)
        else $error("Soft reset left the mode field set.");
    a_fail_latch_on: assert property (
        failure_detected |-> ##[1:2] failure_outputs)
        else $error("Failure did not raise the failure outputs.");
endmodule : sgc_ctrl_regs_sva

// ==== verif/sgc_host_model.sv ====
`timescale 1ns/1ns
// ****
// Host serial master
// ****
module sgc_host_model (
    // Clock
    input  wire logic ref_clk,
    // Serial pins
    output logic      spi_cs_n,
    output logic      spi_sck,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck  = 1'b0;
        spi_mosi = 1'b0;
    end
    // The serial clock rests low between frames; each level spans several cycles.
    task automatic frame(input logic [15:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge ref_clk) spi_cs_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            @(posedge ref_clk) spi_mosi <= tx[15-i];
            @(posedge ref_clk);
            @(negedge ref_clk) rx = {rx[6:0], spi_miso};
            @(posedge ref_clk) spi_sck <= 1'b1;
            repeat (2) @(posedge ref_clk);
            spi_sck <= 1'b0;
        end
        @(posedge ref_clk) spi_cs_n <= 1'b1;
        // A released data line shows the inverse, so a stale bit never passes for data.
        spi_mosi <= ~spi_mosi;
        repeat (4) @(posedge ref_clk);
    endtask : frame
endmodule : sgc_host_model

// ==== verif/tb_sbc_general_control_regs.sv ====
`timescale 1ns/1ns
// ****
// Bench top
// ****
module tb_sbc_general_control_regs;
    import sgc_pkg::*;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic [8:0] ev = 9'h000;
    logic       spi_cs_n, spi_sck, spi_mosi, spi_miso, soft_reset_pulse, reset_output_n;
    logic [1:0] operating_mode, reset_threshold_select;
    logic       secondary_regulator_on, third_regulator_on, main_supply_overvoltage_flag;
    logic       ov_restart_request, ov_fail_safe_request, third_regulator_voltage_select;
    logic       load_sharing_active, failure_outputs, fail_after_first_wd_fault;
    logic       watchdog_stop_disable, watchdog_window_mode, watchdog_bus_start;
    logic       watchdog_parity_ok;
    logic [9:0] watchdog_period_ms;
    logic [7:0] rx;
    int         mismatches = 0, checks = 0, cycles = 0, ro_lows = 0, wd_starts = 0, n;
    int         srs = 0, m;
    sgc_ctrl_regs i_dut (
        .ref_clk, .reset, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso,
        .restart_entry(ev[0]), .over_temp(ev[1]), .main_overvoltage(ev[2]),
        .battery_undervoltage(ev[3]), .failure_detected(ev[4]), .failure_status_clear(ev[5]),
        .fail_safe_active(ev[6]), .soft_fail_safe_cfg(ev[7]), .bus_wake_in_stop(ev[8]),
        .operating_mode, .soft_reset_pulse, .reset_output_n, .secondary_regulator_on,
        .third_regulator_on, .reset_threshold_select, .main_supply_overvoltage_flag,
        .ov_restart_request, .ov_fail_safe_request, .third_regulator_voltage_select,
        .load_sharing_active, .failure_outputs, .fail_after_first_wd_fault,
        .watchdog_stop_disable, .watchdog_window_mode, .watchdog_bus_start,
        .watchdog_period_ms, .watchdog_parity_ok
    );
    sgc_host_model i_host (.ref_clk, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso);
    always #25 ref_clk = ~ref_clk;
    // Pulses are counted on the falling edge, away from the design's own updates.
    always @(negedge ref_clk) begin
        cycles++;
        if (!reset && reset_output_n === 1'b0) ro_lows++;
        if (watchdog_bus_start === 1'b1) wd_starts++;
        if (soft_reset_pulse === 1'b1) srs++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t ns: got %0h, expected %0h", $time, g, e);
        end
    endtask : chk
    task automatic st();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : st
    task automatic xf(input logic [6:0] a, input logic w, input logic [7:0] d);
        i_host.frame({a, w, d}, 16, rx);
        @(negedge ref_clk);
    endtask : xf
    task automatic pu(input int b);
        @(posedge ref_clk) ev[b] <= 1'b1;
        @(posedge ref_clk) ev[b] <= 1'b0;
        st();
    endtask : pu
    task automatic lv(input int b, input logic v);
        @(posedge ref_clk) ev[b] <= v;
        st();
    endtask : lv
    task automatic t_reset();
        logic [7:0] e [3];
        e = '{8'h00, 8'h00, 8'h14};
        for (int a = 1; a < 4; a++) begin
            xf(7'(a), 1'b0, 8'h00);
            chk(rx, e[a-1]);
        end
    endtask : t_reset
    task automatic t_modes();
        for (int k = 0; k < 4; k++) begin
            xf(7'h01, 1'b1, {3'b000, k[1:0], 3'b000});
            chk(secondary_regulator_on, k != 0);
            chk(third_regulator_on, 1'h0);
        end
        xf(7'h01, 1'b1, 8'h2B);
        chk(rx, 8'h18);
        chk(third_regulator_on, 1'h1);
        chk(reset_threshold_select, 2'h3);
        xf(7'h01, 1'b1, 8'h88);
        chk(operating_mode, 2'h2);
        chk(secondary_regulator_on, 1'h0);
        xf(7'h01, 1'b1, 8'h48);
        xf(7'h01, 1'b1, 8'h00);
        chk(rx, 8'h88);
        xf(7'h01, 1'b1, 8'h40);
        chk(operating_mode, 2'h1);
    endtask : t_modes
    task automatic t_restart();
        xf(7'h02, 1'b1, 8'h20);
        chk(failure_outputs, 1'h1);
        xf(7'h01, 1'b1, 8'hB3);
        pu(0);
        chk(failure_outputs, 1'h0);
        xf(7'h02, 1'b0, 8'h00);
        chk(rx, 8'h00);
        xf(7'h01, 1'b1, 8'h10);
        chk(rx, 8'h23);
        pu(1);
        xf(7'h01, 1'b1, 8'h00);
        chk(rx, 8'h00);
    endtask : t_restart
    task automatic t_ov();
        lv(2, 1'b1);
        chk(main_supply_overvoltage_flag, 1'h1);
        chk(ov_restart_request, 1'h0);
        xf(7'h01, 1'b1, 8'h04);
        chk(ov_restart_request, 1'h1);
        lv(7, 1'b1);
        chk(ov_fail_safe_request, 1'h1);
        chk(ov_restart_request, 1'h0);
        lv(2, 1'b0);
        lv(7, 1'b0);
        xf(7'h01, 1'b1, 8'h00);
    endtask : t_ov
    task automatic t_fail();
        pu(4);
        xf(7'h02, 1'b1, 8'h20);
        xf(7'h02, 1'b1, 8'h00);
        chk(failure_outputs, 1'h1);
        pu(5);
        chk(failure_outputs, 1'h0);
    endtask : t_fail
    task automatic t_hw();
        xf(7'h01, 1'b1, 8'h20);
        xf(7'h02, 1'b1, 8'h81);
        chk(third_regulator_voltage_select, 1'h1);
        chk(fail_after_first_wd_fault, 1'h1);
        lv(3, 1'b1);
        chk(third_regulator_on, 1'h0);
        xf(7'h02, 1'b1, 8'h10);
        chk(third_regulator_on, 1'h1);
        lv(3, 1'b0);
        xf(7'h02, 1'b1, 8'h08);
        chk(load_sharing_active, 1'h1);
        xf(7'h01, 1'b1, 8'h80);
        chk(load_sharing_active, 1'h0);
        xf(7'h02, 1'b1, 8'h0A);
        chk(load_sharing_active, 1'h1);
        xf(7'h01, 1'b1, 8'h00);
    endtask : t_hw
    task automatic t_soft();
        xf(7'h02, 1'b1, 8'h99);
        n = ro_lows;
        m = srs;
        xf(7'h01, 1'b1, 8'hC0);
        chk(ro_lows - n, 1);
        chk(srs - m, 1);
        xf(7'h02, 1'b1, 8'hC8);
        chk(rx, 8'h88);
        xf(7'h03, 1'b1, 8'hB7);
        n = ro_lows;
        xf(7'h01, 1'b1, 8'hC0);
        chk(ro_lows - n, 0);
        xf(7'h03, 1'b0, 8'h00);
        chk(rx, 8'h14);
        xf(7'h02, 1'b1, 8'h00);
    endtask : t_soft
    task automatic t_wd();
        logic [9:0] p [8];
        logic [7:0] v;
        p = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h000, 10'h000};
        for (int k = 0; k < 8; k++) begin
            v = {1'b0, k[0], k[1], k[2], 1'b0, k[2:0]};
            v[7] = ^v[6:0];
            xf(7'h03, 1'b1, v);
            chk(watchdog_period_ms, p[k]);
            chk(watchdog_stop_disable, k[0]);
            chk(watchdog_window_mode, k[1]);
            chk(watchdog_parity_ok, 1'h1);
        end
        xf(7'h03, 1'b1, 8'h15);
        chk(rx, v);
        chk(watchdog_parity_ok, 1'h0);
        xf(7'h03, 1'b1, 8'h14);
        n = wd_starts;
        pu(8);
        chk(wd_starts - n, 1);
        xf(7'h03, 1'b1, 8'h84);
        n = wd_starts;
        pu(8);
        chk(wd_starts - n, 0);
    endtask : t_wd
    task automatic t_frame();
        i_host.frame({7'h01, 1'b1, 8'h03}, 12, rx);
        xf(7'h01, 1'b0, 8'h03);
        xf(7'h01, 1'b0, 8'h00);
        chk(rx, 8'h00);
        xf(7'h05, 1'b1, 8'hFF);
        xf(7'h05, 1'b0, 8'h00);
        chk(rx, 8'h00);
    endtask : t_frame
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        st();
        t_reset();
        t_modes();
        t_restart();
        t_ov();
        t_fail();
        t_hw();
        t_soft();
        t_wd();
        t_frame();
        summarize();
    end
endmodule : tb_sbc_general_control_regs
bind sgc_ctrl_regs sgc_ctrl_regs_sva i_sva (
    .ref_clk, .reset, .restart_entry, .over_temp, .main_overvoltage, .soft_fail_safe_cfg,
    .failure_detected, .operating_mode, .soft_reset_pulse, .reset_output_n,
    .secondary_regulator_on, .main_supply_overvoltage_flag, .ov_restart_request,
    .failure_outputs
);
